// >>> sim_pkg.sv
package sim_pkg;
	localparam logic [11:0] SIM_CTRL_STATUS_ADDR = 12'h03a;  // index, byte address is four times it
	localparam logic [11:0] SIM_CTRL_STATUS_BYTE = 12'h0e8;
	localparam int          SIM_BIT_LOCKED       = 3;
	localparam int          SIM_BIT_LOWRST       = 2;
	localparam int          SIM_BIT_WARN         = 1;
	localparam int          SIM_BIT_IRQEN        = 0;
	localparam logic [7:0]  SIM_RESERVED_MASK    = 8'hf0;
	localparam logic        SIM_LOWRST_RESET     = 1'b0;
	localparam logic        SIM_IRQEN_RESET      = 1'b0;

	typedef enum logic [1:0] {
		SIM_THR_LOW    = 2'b00,
		SIM_THR_MEDIUM = 2'b01,
		SIM_THR_HIGH   = 2'b10
	} sim_thr_t;

	typedef struct packed {
		logic     lowSupplyEnable;
		sim_thr_t threshold;
	} sim_option_t;

	typedef struct packed {
		logic waitMode;
		logic haltMode;
		logic globalMask;
		logic irqAck;
		logic illegalOp;
		logic watchdogReset;
		logic powerOnReset;
		logic pllLocked;
	} sim_core_t;
endpackage

// >>> supply_integrity_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sim_supply_integrity_monitor (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire sim_pkg::sim_option_t option,
	input  wire sim_pkg::sim_core_t   core,
	input  wire logic                 lowSupplyCmp,
	input  wire logic                 warnCmp,
	output var sim_pkg::sim_thr_t     thresholdSel,
	output logic                      chipReset,
	output logic                      resetPinOut,
	output logic                      resetPinOe,
	output logic                      clearWatchdogFlag,
	output logic                      warnIrq,
	output logic                      wakeRequest
);
	// ----------------------------------------
	// comparator synchronizers
	// ----------------------------------------
	logic lowSync1;
	logic lowSync2;
	logic warnSync1;
	logic warnSync2;
	logic warnPrev;

	// two flops per comparator, first stage read only by second
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowSync1  <= 1'b0;
			lowSync2  <= 1'b0;
			warnSync1 <= 1'b0;
			warnSync2 <= 1'b0;
		end else begin
			lowSync1  <= lowSupplyCmp;
			lowSync2  <= lowSync1;
			warnSync1 <= warnCmp;
			warnSync2 <= warnSync1;
		end
	end

	// ----------------------------------------
	// reset generation
	// ----------------------------------------
	wire lowReset  = option.lowSupplyEnable & lowSync2;
	wire warnLevel = option.lowSupplyEnable & warnSync2;
	wire warnEdge  = option.lowSupplyEnable & (warnSync2 ^ warnPrev);

	// warning threshold tracks the single option selection
	assign thresholdSel      = option.threshold;
	assign chipReset         = lowReset | core.illegalOp;
	assign resetPinOut       = 1'b0;
	assign resetPinOe        = ~lowReset;
	assign clearWatchdogFlag = lowReset;

	// ----------------------------------------
	// control/status register
	// ----------------------------------------
	logic lockFlag;
	logic lowRstFlag;
	logic irqEn;
	logic pending;

	wire addrHit  = (paddr == sim_pkg::SIM_CTRL_STATUS_BYTE);
	wire wrAccess = psel & penable & pwrite & addrHit;
	wire frozen   = core.haltMode;
	wire [7:0] regView = {4'h0, lockFlag, lowRstFlag, warnLevel, irqEn};

	// lock flag, cleared only by rst_n and by power-on reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lockFlag <= 1'b0;
		end else if (core.powerOnReset) begin
			lockFlag <= 1'b0;
		end else if (core.pllLocked && !frozen) begin
			lockFlag <= 1'b1;
		end
	end

	// cause flag: set wins over a software clear, untouched by other resets
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowRstFlag <= sim_pkg::SIM_LOWRST_RESET;
		end else if (lowReset) begin
			lowRstFlag <= 1'b1;
		end else if (wrAccess && !frozen && !pwdata[sim_pkg::SIM_BIT_LOWRST]) begin
			lowRstFlag <= 1'b0;
		end
	end

	// enable bit, held through chip resets other than rst_n
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqEn <= sim_pkg::SIM_IRQEN_RESET;
		end else if (wrAccess && !frozen) begin
			irqEn <= pwdata[sim_pkg::SIM_BIT_IRQEN];
		end
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	// crossing sets pending; a new crossing beats a same-cycle acknowledge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			warnPrev <= 1'b0;
			pending  <= 1'b0;
		end else begin
			warnPrev <= warnSync2;
			if (warnEdge && irqEn) begin
				pending <= 1'b1;
			end else if (core.irqAck || !irqEn || !option.lowSupplyEnable) begin
				pending <= 1'b0;
			end
		end
	end

	assign warnIrq     = pending & irqEn & ~core.globalMask & option.lowSupplyEnable;
	assign wakeRequest = pending & core.waitMode & ~core.haltMode;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addrHit;

	// read data registered at the setup phase, zero at other setups, held in between
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite && addrHit) begin
			prdata <= {24'h00_0000, regView};
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// pin and chip reset follow a low reset
	a_pin_follows_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lowReset |-> (!resetPinOe && chipReset))
		else $error("reset pin not low");

	// watchdog cause clear needs the option
	a_low_needs_option: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!option.lowSupplyEnable |-> !clearWatchdogFlag)
		else $error("low reset without option");

	// low reset lags the comparator by two edges
	a_sync_two_stage: assert property (@(posedge ref_clk) disable iff (!rst_n)
		option.lowSupplyEnable && $stable(option.lowSupplyEnable) |-> lowReset == $past(lowSupplyCmp, 2))
		else $error("low sync depth wrong");

	// a low reset records its cause
	a_cause_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lowReset |=> lowRstFlag)
		else $error("cause flag not set");

	// upper read bits stay zero
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		prdata[31:4] == 28'h0)
		else $error("reserved bits nonzero");

	// mask or disabled enable blocks the request
	a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(core.globalMask || !irqEn) |-> !warnIrq)
		else $error("irq leaked");

	// a crossing shows up one cycle later
	a_crossing_raises: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(warnEdge && irqEn) ##1 (irqEn && !core.globalMask && option.lowSupplyEnable) |-> warnIrq)
		else $error("crossing lost");

	// vector entry drops the pending request
	a_ack_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(core.irqAck && !warnEdge) |=> !pending)
		else $error("ack not cleared");

	// halt keeps enable and lock still
	a_halt_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(core.haltMode && $past(core.haltMode) && !lowReset && !core.powerOnReset) |-> $stable(irqEn) && $stable(lockFlag))
		else $error("register moved in halt");

	// power-on reset clears the lock flag
	a_lock_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		core.powerOnReset |=> !lockFlag)
		else $error("lock not cleared");

	// ----------------------------------------
	// reset path checks
	// ----------------------------------------
	// low reset clears a standing watchdog cause
	a_wd_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(lowReset && core.watchdogReset) |-> clearWatchdogFlag)
		else $error("watchdog cause kept");

	// watchdog cause clear only from low reset
	a_wd_only_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clearWatchdogFlag |-> lowReset)
		else $error("watchdog cause cleared without low reset");

	// pin released when no low reset
	a_pin_released: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!lowReset |-> resetPinOe)
		else $error("reset pin driven without cause");

	// driven level of the pin is always low
	a_pin_value_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		resetPinOut == 1'b0)
		else $error("reset pin driven high");

	// illegal opcode reaches the chip reset
	a_illegal_resets: assert property (@(posedge ref_clk) disable iff (!rst_n)
		core.illegalOp |-> chipReset)
		else $error("illegal op without reset");

	// chip reset has a known source
	a_reset_sources: assert property (@(posedge ref_clk) disable iff (!rst_n)
		chipReset |-> (lowReset || core.illegalOp))
		else $error("chip reset without source");

	// no low reset with the option off
	a_no_low_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!option.lowSupplyEnable |-> !lowReset)
		else $error("low reset with option off");

	// pin stays released with the option off
	a_pin_needs_option: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!option.lowSupplyEnable |-> resetPinOe)
		else $error("reset pin driven with option off");

	// ----------------------------------------
	// warning path checks
	// ----------------------------------------
	// raw warning synchronizer depth
	a_warn_sync_raw: assert property (@(posedge ref_clk) disable iff (!rst_n)
		warnSync2 == $past(warnCmp, 2))
		else $error("warn sync depth wrong");

	// warning flag tracks the comparator level
	a_warn_sync_depth: assert property (@(posedge ref_clk) disable iff (!rst_n)
		option.lowSupplyEnable && $stable(option.lowSupplyEnable) |-> warnLevel == $past(warnCmp, 2))
		else $error("warn flag not real time");

	// warning flag and request dead with option off
	a_warn_dead_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!option.lowSupplyEnable |-> (!warnLevel && !warnIrq))
		else $error("warning active with option off");

	// enabled crossing sets pending
	a_crossing_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(warnEdge && irqEn) |=> pending)
		else $error("crossing not pending");

	// pending never rises without a crossing
	a_pend_no_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!pending && !(warnEdge && irqEn)) |=> !pending)
		else $error("pending without crossing");

	// disabling the enable drops pending
	a_en_off_drops: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!irqEn |=> !pending)
		else $error("pending kept while disabled");

	// request needs pending and enable
	a_irq_needs_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
		warnIrq |-> (pending && irqEn))
		else $error("request without pending");

	// unmasked pending reaches the core
	a_irq_forward: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pending && irqEn && !core.globalMask && option.lowSupplyEnable) |-> warnIrq)
		else $error("request not forwarded");

	// pending wakes the core from wait
	a_wait_wakes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pending && core.waitMode && !core.haltMode) |-> wakeRequest)
		else $error("no wake from wait");

	// no wake outside wait
	a_wake_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!core.waitMode |-> !wakeRequest)
		else $error("wake outside wait");

	// warning never wakes from halt
	a_no_halt_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
		core.haltMode |-> !wakeRequest)
		else $error("wake from halt");

	// ----------------------------------------
	// register checks
	// ----------------------------------------
	// software clear of the cause flag
	a_cause_sw_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrAccess && !frozen && !lowReset && !pwdata[sim_pkg::SIM_BIT_LOWRST]) |=> !lowRstFlag)
		else $error("cause flag not cleared");

	// cause flag moves only by low reset or clear
	a_cause_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!lowReset && !(wrAccess && !frozen && !pwdata[sim_pkg::SIM_BIT_LOWRST])) |=> $stable(lowRstFlag))
		else $error("cause flag moved");

	// halt holds the cause flag
	a_halt_cause_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(frozen && !lowReset) |=> $stable(lowRstFlag))
		else $error("cause flag moved in halt");

	// enable takes the written bit
	a_en_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrAccess && !frozen) |=> irqEn == $past(pwdata[sim_pkg::SIM_BIT_IRQEN]))
		else $error("enable write lost");

	// enable holds without a write
	a_en_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(wrAccess && !frozen) |=> $stable(irqEn))
		else $error("enable moved");

	// writes in halt are ignored
	a_halt_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrAccess && frozen) |=> $stable(irqEn))
		else $error("write taken in halt");

	// lock flag sets on lock outside halt
	a_lock_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(core.pllLocked && !frozen && !core.powerOnReset) |=> lockFlag)
		else $error("lock not set");

	// lock flag sticks until power-on reset
	a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(lockFlag && !core.powerOnReset) |=> lockFlag)
		else $error("lock flag dropped");

	// halt holds the lock flag
	a_halt_lock_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(frozen && !core.powerOnReset) |=> $stable(lockFlag))
		else $error("lock flag moved in halt");

	// ----------------------------------------
	// bus checks
	// ----------------------------------------
	// read returns the register view
	a_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && addrHit) |=> prdata[7:0] == $past(regView))
		else $error("read data wrong");

	// read shows the live warning flag
	a_warn_bit_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && addrHit) |=> prdata[sim_pkg::SIM_BIT_WARN] == $past(warnLevel))
		else $error("warn bit read wrong");

	// read data stands through the access phase
	a_read_stands: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(psel && penable) |=> $stable(prdata))
		else $error("read data moved");

	// unmapped setup gives zero data
	a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(psel && !penable && !addrHit) |=> prdata == 32'h0000_0000)
		else $error("unmapped data nonzero");

	// unmapped access reports an error
	a_err_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(psel && penable && !addrHit) |-> pslverr)
		else $error("unmapped without error");

	// mapped access never reports an error
	a_err_mapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
		addrHit |-> !pslverr)
		else $error("error on mapped access");
endmodule
`default_nettype wire

// >>> sim_core_irq_model.sv
`timescale 1ns/100ps
`default_nettype none
module sim_core_irq_model (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic warnIrq,
	output logic      irqAck
);
	logic [1:0] waitCnt;

	// core enters the vector three cycles after a request, acknowledging for one cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt <= 2'h0;
			irqAck  <= 1'b0;
		end else begin
			irqAck  <= (waitCnt == 2'h2);
			waitCnt <= (warnIrq && !irqAck && waitCnt != 2'h2) ? waitCnt + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic                ref_clk = 1'b0, rst_n = 1'b0;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]         paddr = 12'h0;
	logic [31:0]         pwdata = 32'h0, prdata, r;
	logic                pready, pslverr, e, lowCmp = 1'b0, warnCmp = 1'b0;
	logic                chipReset, pinOut, pinOe, clearWd, warnIrq, wake, ack, irqPrev;
	sim_pkg::sim_option_t opt = 3'b100;
	sim_pkg::sim_core_t  coreIn = 8'h04, coreAll;
	sim_pkg::sim_thr_t   thrSel;
	int                  n_mismatch = 0, tests_run = 0, irqCount = 0, irq0;
	logic [5:0]          rows [4] = '{6'b110010, 6'b100101, 6'b011001, 6'b111010};
	localparam logic [11:0] A = sim_pkg::SIM_CTRL_STATUS_BYTE;

	// clock, acknowledge splice and rising-edge count of the request
	always #5 ref_clk = ~ref_clk;
	assign coreAll = {coreIn[7:5], ack, coreIn[3:0]};
	always @(posedge ref_clk) begin
		irqPrev <= warnIrq;
		if (warnIrq === 1'b1 && irqPrev === 1'b0) irqCount++;
	end

	sim_supply_integrity_monitor dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.option(opt), .core(coreAll), .lowSupplyCmp(lowCmp), .warnCmp(warnCmp), .thresholdSel(thrSel),
		.chipReset(chipReset), .resetPinOut(pinOut), .resetPinOe(pinOe), .clearWatchdogFlag(clearWd),
		.warnIrq(warnIrq), .wakeRequest(wake));
	sim_core_irq_model core (.ref_clk(ref_clk), .rst_n(rst_n), .warnIrq(warnIrq), .irqAck(ack));

	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chkBit(input string s, input logic x, input logic g);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", s, x, g);
		end
	endtask
	task automatic chkWord(input string s, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, x, g);
		end
	endtask
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	// watchdog against a hang
	initial begin
		#100us;
		n_mismatch++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, A, 32'h0);
		chkWord("reg after reset", 32'h0, r);
		chkBit("mapped no error", 1'b0, e);
		foreach (rows[i]) begin
			opt <= {rows[i][5], rows[i][3:2]};
			lowCmp <= rows[i][4];
			repeat (4) @(posedge ref_clk);
			chkBit("chipReset", rows[i][1], chipReset);
			chkBit("resetPinOe", rows[i][0], pinOe);
			chkBit("clearWatchdogFlag", rows[i][1], clearWd);
			chkWord("thresholdSel", {30'h0, rows[i][3:2]}, {30'h0, thrSel});
		end
		lowCmp <= 1'b0;
		coreIn <= 8'h01;
		repeat (4) @(posedge ref_clk);
		coreIn <= 8'h00;
		apb(1'b0, A, 32'h0);
		chkWord("reg lock and cause", 32'h0c, r);
		apb(1'b1, A, 32'hff);
		apb(1'b0, A, 32'h0);
		chkWord("reg after write ff", 32'h0d, r);
		apb(1'b1, A, 32'h01);
		apb(1'b0, A, 32'h0);
		chkWord("reg cause cleared", 32'h09, r);
		irq0 = irqCount;
		warnCmp <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chkBit("falling crossing irq", 1'b1, irqCount != irq0);
		chkBit("irq after ack", 1'b0, warnIrq);
		coreIn <= 8'h40;
		apb(1'b1, A, 32'h00);
		apb(1'b0, A, 32'h0);
		chkWord("reg frozen in halt", 32'h0b, r);
		coreIn <= 8'h20;
		warnCmp <= 1'b0;
		irq0 = irqCount;
		repeat (8) @(posedge ref_clk);
		chkBit("masked irq", 1'b0, warnIrq);
		coreIn <= 8'h00;
		repeat (8) @(posedge ref_clk);
		chkBit("rising crossing irq", 1'b1, irqCount != irq0);
		coreIn <= 8'h80;
		warnCmp <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chkBit("wake in wait", 1'b1, wake);
		repeat (6) @(posedge ref_clk);
		chkBit("reset pin value", 1'b0, pinOut);
		opt <= 3'b010;
		coreIn <= 8'h02;
		repeat (4) @(posedge ref_clk);
		chkBit("irq dead without option", 1'b0, warnIrq);
		coreIn <= 8'h00;
		apb(1'b0, A, 32'h0);
		chkWord("warn off and lock cleared", 32'h01, r);
		apb(1'b0, 12'h0f0, 32'h0);
		chkBit("unmapped error", 1'b1, e);
		chkWord("unmapped data", 32'h0, r);
		coreIn <= 8'h08;
		repeat (2) @(posedge ref_clk);
		chkBit("illegal op reset", 1'b1, chipReset);
		test_done();
	end
endmodule
`default_nettype wire
